// [verilog/systick_pkg.sv]
// Package for the system tick timers and watchdog block.
// Assumes an 8-bit special-function register port from the CPU core.
package systick_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] REBOOT_OFF = 8'h00_F7;
  localparam logic [7:0] LONG_OFF   = 8'h00_F9;
  localparam logic [7:0] SHORT_OFF  = 8'h00_FA;
  localparam logic [7:0] MICRO_OFF  = 8'h00_FB;
  localparam logic [7:0] MLOW_OFF   = 8'h00_FC;
  localparam logic [7:0] MHIGH_OFF  = 8'h00_FD;
  localparam logic [7:0] HUND_OFF   = 8'h00_FE;
  localparam logic [7:0] DOG_OFF    = 8'h00_FF;

  // ==========================================================
  // Field positions
  localparam int SOFT_REBOOT_BIT = 0;
  localparam int LOAD_NOW_BIT    = 7;
  localparam int DOG_ARM_BIT     = 7;
  localparam int DOG_DISARM_BIT  = 6;
  localparam int DOG_KICK_BIT    = 5;
  localparam int DOG_PERIOD_W    = 5;
  localparam int MICRO_W         = 6;
  localparam int COUNT_W         = 7;

  // ==========================================================
  // Reset values
  localparam logic [7:0] REBOOT_RST = 8'h00_00;
  localparam logic [6:0] LONG_RST   = 7'h00_7F;
  localparam logic [6:0] SHORT_RST  = 7'h00_7F;
  localparam logic [5:0] MICRO_RST  = 6'h00_03;
  localparam logic [7:0] MLOW_RST   = 8'h00_9F;
  localparam logic [7:0] MHIGH_RST  = 8'h00_0F;
  localparam logic [6:0] HUND_RST   = 7'h00_63;
  localparam logic [7:0] DOG_RST    = 8'h00_00;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic micro;
    logic milli;
    logic hundred;
  } ticks_t;

endpackage : systick_pkg

// [verilog/system_tick_timers_watchdog.sv]
// System tick dividers, two interval timers, watchdog, reboot request.
// Assumes a single-cycle SFR write/read strobe from the CPU core and
// power-down and interrupt-enable levels from neighbouring registers.
//
// Behaviour
// - Writing one then zero to the reboot bit requests a full reset.
// - Microsecond tick every divisor field plus one clocks; field resets 3.
// - Millisecond tick every high*256+low+1 clocks; resets 9F and 0F.
// - Micro tick feeds flash write timing, milli tick flash erase timing.
// - Hundred-ms tick every hundred divisor plus one milli ticks; resets 63.
// - Long interrupt every count plus one hundred-ms ticks; count resets 7F.
// - Long interval spans 100 ms up to 12.8 s at default base.
// - Reading long register clears its pending flag.
// - Short interrupt every count plus one milli ticks; count resets 7F.
// - Short pending clears on a read of the short register alone.
// - Load-now bit reads zero; one loads at once, zero at expiry.
// - Writing one then zero to arm bit enables watchdog counting.
// - Writing one then zero to disarm bit stops watchdog counting.
// - Writing one then zero to kick bit restarts watchdog counter.
// - Watchdog expires after period+1 to period+2 hundred-ms ticks.
// - Watchdog interrupt priority is high when the level bit is one.
// - Watchdog request reaches the CPU only when its enable is one.
// - Tick timers stop while their power-down bit is one.
// - Watchdog stops while its power-down bit is one.

`timescale 1ns/1ps

// ============================================================
// Reloadable down counter
module reload_counter #(
  parameter int         W   = 8,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // Counting
  input  wire logic         tick,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic [W-1:0] reload_val,
  output logic              expire
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // Expiry is a pulse on the tick that finds zero
  assign expire = tick & (cnt_r == '0);

  // Immediate load beats counting; reload picks up delayed writes
  always_comb begin
    if (load) begin
      cnt_nxt = load_val;
    end else if (expire) begin
      cnt_nxt = reload_val;
    end else if (tick) begin
      cnt_nxt = cnt_r - W'(1);
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) cnt_r <= RST;
    else     cnt_r <= cnt_nxt;
  end

endmodule : reload_counter

// ============================================================
// Top level
module system_tick_timers_watchdog #(
  parameter int DOG_W = systick_pkg::DOG_PERIOD_W
) (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst,
  // SFR port
  input  wire systick_pkg::sfr_req_t sfr,
  output logic [7:0]               sfr_rdata,
  // Controls from neighbouring registers
  input  wire logic                tick_powerdown,
  input  wire logic                dog_powerdown,
  input  wire logic                dog_irq_on,
  input  wire logic                dog_irq_level,
  // Ticks toward flash timing
  output systick_pkg::ticks_t      ticks,
  // Events and requests
  output logic                     long_irq_pend,
  output logic                     short_irq_pend,
  output logic                     dog_expire,
  output logic                     dog_irq_hi,
  output logic                     dog_irq_lo,
  output logic                     reboot_req
);

  // ==========================================================
  // Decode
  wire wr_reboot = sfr.wr & (sfr.addr == systick_pkg::REBOOT_OFF);
  wire wr_long   = sfr.wr & (sfr.addr == systick_pkg::LONG_OFF);
  wire wr_short  = sfr.wr & (sfr.addr == systick_pkg::SHORT_OFF);
  wire wr_micro  = sfr.wr & (sfr.addr == systick_pkg::MICRO_OFF);
  wire wr_mlow   = sfr.wr & (sfr.addr == systick_pkg::MLOW_OFF);
  wire wr_mhigh  = sfr.wr & (sfr.addr == systick_pkg::MHIGH_OFF);
  wire wr_hund   = sfr.wr & (sfr.addr == systick_pkg::HUND_OFF);
  wire wr_dog    = sfr.wr & (sfr.addr == systick_pkg::DOG_OFF);
  wire rd_long   = sfr.rd & (sfr.addr == systick_pkg::LONG_OFF);
  wire rd_short  = sfr.rd & (sfr.addr == systick_pkg::SHORT_OFF);
  wire load_now  = sfr.wdata[systick_pkg::LOAD_NOW_BIT];

  // ==========================================================
  // Registers
  logic [7:0] reboot_r;
  logic [6:0] long_r;
  logic [6:0] short_r;
  logic [5:0] micro_r;
  logic [7:0] mlow_r;
  logic [7:0] mhigh_r;
  logic [6:0] hund_r;
  logic [7:0] dog_r;

  // Plain storage of written values
  always_ff @(posedge mclk) begin
    if (rst) begin
      reboot_r <= systick_pkg::REBOOT_RST;
      long_r   <= systick_pkg::LONG_RST;
      short_r  <= systick_pkg::SHORT_RST;
      micro_r  <= systick_pkg::MICRO_RST;
      mlow_r   <= systick_pkg::MLOW_RST;
      mhigh_r  <= systick_pkg::MHIGH_RST;
      hund_r   <= systick_pkg::HUND_RST;
      dog_r    <= systick_pkg::DOG_RST;
    end else begin
      if (wr_reboot) reboot_r <= {7'h0_0, sfr.wdata[0]};
      if (wr_long)   long_r   <= sfr.wdata[6:0];
      if (wr_short)  short_r  <= sfr.wdata[6:0];
      if (wr_micro)  micro_r  <= sfr.wdata[5:0];
      if (wr_mlow)   mlow_r   <= sfr.wdata;
      if (wr_mhigh)  mhigh_r  <= sfr.wdata;
      if (wr_hund)   hund_r   <= sfr.wdata[6:0];
      if (wr_dog)    dog_r    <= sfr.wdata;
    end
  end

  // ==========================================================
  // One-then-zero sequences: stored bit one, new write zero
  wire seq_reboot = wr_reboot & reboot_r[systick_pkg::SOFT_REBOOT_BIT]
                    & ~sfr.wdata[systick_pkg::SOFT_REBOOT_BIT];
  wire seq_arm    = wr_dog & dog_r[systick_pkg::DOG_ARM_BIT]
                    & ~sfr.wdata[systick_pkg::DOG_ARM_BIT];
  wire seq_disarm = wr_dog & dog_r[systick_pkg::DOG_DISARM_BIT]
                    & ~sfr.wdata[systick_pkg::DOG_DISARM_BIT];
  wire seq_kick   = wr_dog & dog_r[systick_pkg::DOG_KICK_BIT]
                    & ~sfr.wdata[systick_pkg::DOG_KICK_BIT];

  // ==========================================================
  // Tick chain, halted while powered down
  wire run = ~tick_powerdown;
  logic micro_tk;
  logic milli_tk;
  logic hund_tk;
  logic long_tk;
  logic short_tk;

  reload_counter #(.W(6), .RST(systick_pkg::MICRO_RST)) u_micro (
    .mclk       (mclk),
    .rst        (rst),
    .tick       (run),
    .load       (1'b0),
    .load_val   (micro_r),
    .reload_val (micro_r),
    .expire     (micro_tk)
  );

  reload_counter #(.W(16),
    .RST({systick_pkg::MHIGH_RST, systick_pkg::MLOW_RST})) u_milli (
    .mclk       (mclk),
    .rst        (rst),
    .tick       (run),
    .load       (1'b0),
    .load_val   ({mhigh_r, mlow_r}),
    .reload_val ({mhigh_r, mlow_r}),
    .expire     (milli_tk)
  );

  reload_counter #(.W(7), .RST(systick_pkg::HUND_RST)) u_hund (
    .mclk       (mclk),
    .rst        (rst),
    .tick       (milli_tk),
    .load       (wr_hund & load_now),
    .load_val   (sfr.wdata[6:0]),
    .reload_val (hund_r),
    .expire     (hund_tk)
  );

  // Long timer runs on the hundred-ms tick, 100 ms to 12.8 s
  reload_counter #(.W(7), .RST(systick_pkg::LONG_RST)) u_long (
    .mclk       (mclk),
    .rst        (rst),
    .tick       (hund_tk),
    .load       (wr_long & load_now),
    .load_val   (sfr.wdata[6:0]),
    .reload_val (long_r),
    .expire     (long_tk)
  );

  reload_counter #(.W(7), .RST(systick_pkg::SHORT_RST)) u_short (
    .mclk       (mclk),
    .rst        (rst),
    .tick       (milli_tk),
    .load       (wr_short & load_now),
    .load_val   (sfr.wdata[6:0]),
    .reload_val (short_r),
    .expire     (short_tk)
  );

  // ==========================================================
  // Pending flags: a new expiry wins over the clearing read
  logic long_pend_r;
  logic short_pend_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      long_pend_r  <= 1'b0;
      short_pend_r <= 1'b0;
    end else begin
      long_pend_r  <= long_tk | (long_pend_r & ~rd_long);
      short_pend_r <= short_tk | (short_pend_r & ~rd_short);
    end
  end

  // ==========================================================
  // Watchdog
  logic             dog_en_r;
  logic [DOG_W:0]   dog_cnt_r;
  logic             dog_exp_r;

  wire dog_run = dog_en_r & ~dog_powerdown;
  // Counting from a restart, the period+2'th tick lands one to two
  // periods of slack after the kick, which is the allowed window
  wire [DOG_W:0] dog_lim = {1'b0, dog_r[DOG_W-1:0]} + (DOG_W+1)'(1);
  wire dog_hit = dog_run & hund_tk & (dog_cnt_r == dog_lim);

  // Enable state; arm beats disarm when both land together
  always_ff @(posedge mclk) begin
    if (rst)             dog_en_r <= 1'b0;
    else if (seq_arm)    dog_en_r <= 1'b1;
    else if (seq_disarm) dog_en_r <= 1'b0;
  end

  // Counter restarts on kick and on each expiry
  always_ff @(posedge mclk) begin
    if (rst)                      dog_cnt_r <= '0;
    else if (seq_kick | dog_hit)  dog_cnt_r <= '0;
    else if (dog_run & hund_tk)   dog_cnt_r <= dog_cnt_r + (DOG_W+1)'(1);
  end

  always_ff @(posedge mclk) begin
    if (rst) dog_exp_r <= 1'b0;
    else     dog_exp_r <= dog_hit;
  end

  // ==========================================================
  // Registered outputs
  logic       reboot_q;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  systick_pkg::ticks_t ticks_r;

  // Load-now bits always read back as zero
  always_comb begin
    case (sfr.addr)
      systick_pkg::REBOOT_OFF: rdata_nxt = reboot_r;
      systick_pkg::LONG_OFF:   rdata_nxt = {1'b0, long_r};
      systick_pkg::SHORT_OFF:  rdata_nxt = {1'b0, short_r};
      systick_pkg::MICRO_OFF:  rdata_nxt = {2'b00, micro_r};
      systick_pkg::MLOW_OFF:   rdata_nxt = mlow_r;
      systick_pkg::MHIGH_OFF:  rdata_nxt = mhigh_r;
      systick_pkg::HUND_OFF:   rdata_nxt = {1'b0, hund_r};
      systick_pkg::DOG_OFF:    rdata_nxt = dog_r;
      default:                 rdata_nxt = 8'h00_00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_r  <= 8'h00_00;
      reboot_q <= 1'b0;
      ticks_r  <= '0;
    end else begin
      if (sfr.rd) rdata_r <= rdata_nxt;
      reboot_q <= seq_reboot;
      ticks_r  <= '{micro: micro_tk, milli: milli_tk,
                    hundred: hund_tk};
    end
  end

  // ==========================================================
  // Port drive
  assign sfr_rdata      = rdata_r;
  assign ticks          = ticks_r;
  assign long_irq_pend  = long_pend_r;
  assign short_irq_pend = short_pend_r;
  assign dog_expire     = dog_exp_r;
  assign reboot_req     = reboot_q;
  // Enable gates the request, level picks the priority line
  assign dog_irq_hi = dog_exp_r & dog_irq_on & dog_irq_level;
  assign dog_irq_lo = dog_exp_r & dog_irq_on & ~dog_irq_level;

endmodule : system_tick_timers_watchdog

// [bench/systick_assertions.sv]
// Port checker for the tick timers and watchdog block.
// Assumes binding to the top module; divider at 0xFB left at reset.
`timescale 1ns/1ps

// ==========================================================
// Checker
module systick_checker #(
  parameter int DOG_W = 5
) (
  // Clock and reset
  input wire logic                  mclk,
  input wire logic                  rst,
  // Register port
  input wire systick_pkg::sfr_req_t sfr,
  // Controls
  input wire logic                  tick_powerdown,
  input wire logic                  dog_powerdown,
  input wire logic                  dog_irq_on,
  input wire logic                  dog_irq_level,
  // Block outputs
  input wire systick_pkg::ticks_t   ticks,
  input wire logic                  long_irq_pend,
  input wire logic                  short_irq_pend,
  input wire logic                  dog_expire,
  input wire logic                  dog_irq_hi,
  input wire logic                  dog_irq_lo,
  input wire logic                  reboot_req
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Decodes; the reboot bit fires on a zero after a stored one
  logic reb_r;
  wire  reb_hit  = sfr.wr && sfr.addr == systick_pkg::REBOOT_OFF;
  wire  reb_fire = reb_hit && !sfr.wdata[0] && reb_r;
  wire  rd_long  = sfr.rd && sfr.addr == systick_pkg::LONG_OFF;
  wire  rd_short = sfr.rd && sfr.addr == systick_pkg::SHORT_OFF;

  // Mirror of the stored reboot bit
  always_ff @(posedge mclk) begin
    if (rst) reb_r <= 1'b0;
    else if (reb_hit) reb_r <= sfr.wdata[0];
  end

  reboot_fire_a: assert property (reb_fire |=> reboot_req)
    else $error("reboot request missing");
  reboot_only_a: assert property (reboot_req |-> $past(reb_fire))
    else $error("reboot request without sequence");
  dog_high_a: assert property (
    dog_irq_hi == (dog_expire && dog_irq_on && dog_irq_level))
    else $error("high watchdog request wrong");
  dog_low_a: assert property (
    dog_irq_lo == (dog_expire && dog_irq_on && !dog_irq_level))
    else $error("low watchdog request wrong");
  // Three cycles tolerate the registered lag of the tick outputs
  tick_freeze_a: assert property (
    tick_powerdown [*3] |-> !ticks.micro && !ticks.milli)
    else $error("tick while powered down");
  dog_freeze_a: assert property (dog_powerdown [*3] |-> !dog_expire)
    else $error("watchdog expiry while powered down");
  micro_period_a: assert property (
    (ticks.micro && !tick_powerdown) ##1 !tick_powerdown [*3]
      |-> !ticks.micro ##1 ticks.micro)
    else $error("micro tick period wrong");
  long_clear_a: assert property (
    rd_long |=> !long_irq_pend or ##[0:1] ticks.hundred)
    else $error("long pending not cleared by read");
  short_clear_a: assert property (
    rd_short |=> !short_irq_pend or ##[0:1] ticks.milli)
    else $error("short pending not cleared by read");

  reboot_c: cover property (reboot_req);
  dog_c: cover property (dog_expire && dog_irq_hi);
  long_c: cover property ($rose(long_irq_pend));
endmodule : systick_checker

bind system_tick_timers_watchdog systick_checker #(.DOG_W(DOG_W)) chk_i (
  .mclk(mclk), .rst(rst), .sfr(sfr), .tick_powerdown(tick_powerdown),
  .dog_powerdown(dog_powerdown), .dog_irq_on(dog_irq_on),
  .dog_irq_level(dog_irq_level), .ticks(ticks),
  .long_irq_pend(long_irq_pend), .short_irq_pend(short_irq_pend),
  .dog_expire(dog_expire), .dog_irq_hi(dog_irq_hi),
  .dog_irq_lo(dog_irq_lo), .reboot_req(reboot_req)
);

// [bench/testbench.sv]
// Self-checking bench for the tick timers and watchdog block.
// Assumes the checker is bound separately; inputs move at falling edges.
`timescale 1ns/1ps

module testbench;
  // ==========================================================
  // Stimulus and observation
  logic                  mclk    = 1'b0;
  logic                  rst     = 1'b1;
  systick_pkg::sfr_req_t sfr     = '0;
  logic                  tick_pd = 1'b1;
  logic                  dog_pd  = 1'b0;
  logic                  irq_on  = 1'b1;
  logic                  irq_lvl = 1'b1;
  logic [7:0]            rdata;
  systick_pkg::ticks_t   ticks;
  logic                  long_p, short_p, dog_exp, irq_hi, irq_lo, reboot;
  int                    errors = 0;
  int                    samples_checked = 0;
  int                    cyc = 0;
  logic [7:0] rst_val [9] = '{8'h00_00, 8'h00_00, 8'h00_7F, 8'h00_7F,
    8'h00_03, 8'h00_9F, 8'h00_0F, 8'h00_63, 8'h00_00};
  wire [6:0] ev = {reboot, dog_exp, long_p, short_p, ticks.hundred,
    ticks.milli, ticks.micro};

  system_tick_timers_watchdog dut (
    .mclk(mclk), .rst(rst), .sfr(sfr), .sfr_rdata(rdata),
    .tick_powerdown(tick_pd), .dog_powerdown(dog_pd),
    .dog_irq_on(irq_on), .dog_irq_level(irq_lvl), .ticks(ticks),
    .long_irq_pend(long_p), .short_irq_pend(short_p),
    .dog_expire(dog_exp), .dog_irq_hi(irq_hi), .dog_irq_lo(irq_lo),
    .reboot_req(reboot)
  );

  // Clock, and a ceiling well above the roughly 4500 cycles the run needs
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic print_verdict();
    if (errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge mclk);
    sfr.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    sfr = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00_00};
    @(negedge mclk);
    sfr.rd = 1'b0;
    d = rdata;
  endtask : rd

  // Bounded wait; 5000 covers the first slow millisecond reload
  task automatic wait_ev(input int b, output int t);
    int n;
    n = 0;
    @(negedge mclk);
    while (ev[b] !== 1'b1 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    if (n == 5000) errors++;
    t = cyc;
  endtask : wait_ev

  // Samples the current falling edge first, so a pulse launched by the
  // last write of the caller is not missed
  task automatic count_ev(input int b, input int w, output int n);
    n = 0;
    repeat (w) begin
      if (ev[b] === 1'b1) n++;
      @(negedge mclk);
    end
  endtask : count_ev

  // Distance between two events; two reads clear a pending level even
  // when a new expiry wins over the first clearing read
  task automatic gap(input int b, input logic [7:0] a, output int p);
    logic [7:0] d;
    int t1;
    int t2;
    rd(a, d);
    rd(a, d);
    wait_ev(b, t1);
    rd(a, d);
    wait_ev(b, t2);
    p = t2 - t1;
  endtask : gap

  // ==========================================================
  // Scenarios
  task automatic reset_values();
    logic [7:0] d;
    for (int i = 0; i < 9; i++) begin
      rd(8'h00_F7 + 8'(i), d);
      chk("reset value", d, rst_val[i]);
    end
  endtask : reset_values

  task automatic reboot_seq();
    int n;
    wr(systick_pkg::REBOOT_OFF, 8'h00_01);
    wr(systick_pkg::REBOOT_OFF, 8'h00_00);
    count_ev(6, 4, n);
    chk("reboot pulse", 8'(n), 8'h00_01);
    wr(systick_pkg::REBOOT_OFF, 8'h00_00);
    count_ev(6, 4, n);
    chk("lone zero", 8'(n), 8'h00_00);
  endtask : reboot_seq

  // Short divisors keep the run small: milli 4, hundred 8 clocks
  task automatic ticks_run();
    int p;
    logic [7:0] d;
    wr(systick_pkg::MLOW_OFF, 8'h00_03);
    wr(systick_pkg::MHIGH_OFF, 8'h00_00);
    wr(systick_pkg::HUND_OFF, 8'h00_81);
    wr(systick_pkg::SHORT_OFF, 8'h00_82);
    wr(systick_pkg::LONG_OFF, 8'h00_81);
    rd(systick_pkg::LONG_OFF, d);
    chk("load now readback", d, 8'h00_01);
    tick_pd = 1'b0;
    wait_ev(1, p);
    gap(0, 8'h00_F8, p);
    chk("micro period", 8'(p), 8'h00_04);
    gap(1, 8'h00_F8, p);
    chk("milli period", 8'(p), 8'h00_04);
    gap(2, 8'h00_F8, p);
    chk("hundred period", 8'(p), 8'h00_08);
    gap(3, systick_pkg::SHORT_OFF, p);
    chk("short period", 8'(p), 8'h00_0C);
    gap(4, systick_pkg::LONG_OFF, p);
    chk("long period", 8'(p), 8'h00_10);
    wr(systick_pkg::SHORT_OFF, 8'h00_05);
    gap(3, systick_pkg::SHORT_OFF, p);
    chk("deferred load", 8'(p), 8'h00_18);
  endtask : ticks_run

  task automatic dog_run();
    int p;
    wr(systick_pkg::DOG_OFF, 8'h00_81);
    wr(systick_pkg::DOG_OFF, 8'h00_01);
    wr(systick_pkg::DOG_OFF, 8'h00_21);
    wr(systick_pkg::DOG_OFF, 8'h00_01);
    gap(5, 8'h00_F8, p);
    chk("dog period", 8'(p), 8'h00_18);
    for (int i = 0; i < 3; i++) begin
      irq_on = (i != 2);
      irq_lvl = (i == 0);
      wait_ev(5, p);
      chk("dog high", {7'h00, irq_hi}, {7'h00, irq_on & irq_lvl});
      chk("dog low", {7'h00, irq_lo}, {7'h00, irq_on & ~irq_lvl});
    end
    // Kick late, so an unkicked expiry would fall inside the window
    repeat (10) @(negedge mclk);
    wr(systick_pkg::DOG_OFF, 8'h00_21);
    wr(systick_pkg::DOG_OFF, 8'h00_01);
    count_ev(5, 14, p);
    chk("after kick", 8'(p), 8'h00_00);
    dog_pd = 1'b1;
    count_ev(5, 60, p);
    chk("dog frozen", 8'(p), 8'h00_00);
    dog_pd = 1'b0;
    wr(systick_pkg::DOG_OFF, 8'h00_41);
    wr(systick_pkg::DOG_OFF, 8'h00_01);
    count_ev(5, 60, p);
    chk("dog disarmed", 8'(p), 8'h00_00);
  endtask : dog_run

  // Main sequence
  initial begin
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    reset_values();
    reboot_seq();
    ticks_run();
    dog_run();
    print_verdict();
  end
endmodule : testbench
